// ==== psru_core.sv ====
// psru_core: processor state word, its AHB-Lite slave and exception update.
// assumes exception and interrupt events are one-cycle pulses from core logic.
`timescale 1ns/1ps
module psru_core (
	input wire logic clk, // core clock
	input wire logic reset, // sync reset, active high
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write
	input wire logic [2:0] hsize, // size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // response
	input wire psru_pkg::psru_irq_s irq_req, // controller request
	input wire psru_pkg::psru_exc_s exc_in, // exception event
	output logic irq_accept, // request may be taken
	output psru_pkg::psru_state_s state, // state word
	output logic [31:0] saved_word // saved status copy
);
	psru_pkg::psru_state_s st_q, st_d;
	logic [31:0] sav_q, sav_d;
	logic wr_pend_q, wr_pend_d;
	logic [31:0] addr_q, addr_d;
	logic [31:0] rd_q, rd_d;
	logic take_copy;
	logic [31:0] st_word;
	logic addr_phase;
	logic sw_state_wr;
	logic sw_saved_wr;
	logic rd_state_req;
	logic rd_saved_req;
	logic nmi_take;
	logic wr_ssie;
	logic [psru_pkg::SET_W-1:0] wr_prs;

	function automatic logic [31:0] pack_word(input psru_pkg::psru_state_s s);
		logic [31:0] w;
		w = 32'h00000000;
		w[psru_pkg::POS_SSIE] = s.ssie;
		w[psru_pkg::POS_NMI] = s.nmi;
		w[psru_pkg::POS_PRS +: psru_pkg::SET_W] = s.previous_reg_set;
		w[psru_pkg::POS_CRS +: psru_pkg::SET_W] = s.current_reg_set;
		w[psru_pkg::POS_IL +: 6] = s.il;
		w[psru_pkg::POS_IH] = s.ih;
		w[psru_pkg::POS_EH] = s.eh;
		w[psru_pkg::POS_U] = s.u;
		w[psru_pkg::POS_PIE] = s.pie;
		return w;
	endfunction : pack_word

	assign st_word = pack_word(st_q);

	// maskable path compares level; same-set requests gated by the enable
	always_comb
	begin
		irq_accept = 1'b0;
		if (irq_req.valid && psru_pkg::HAS_EIC)
		begin
			if (irq_req.nmi)
				irq_accept = 1'b1;
			else if (st_q.pie && (irq_req.level > st_q.il))
				irq_accept = (irq_req.rset != st_q.current_reg_set) || st_q.ssie;
		end
	end

	// copy condition sampled against the old exception mode bit
	assign take_copy = !psru_pkg::HAS_MMU || exc_in.is_break || !st_q.eh;

	// bus decode shared by the update logic and its checks
	assign addr_phase = hsel && hready && (htrans == psru_pkg::HTRANS_NONSEQ);
	assign sw_state_wr = wr_pend_q && (addr_q == psru_pkg::OFS_STATE);
	assign sw_saved_wr = wr_pend_q && (addr_q == psru_pkg::OFS_SAVED);
	assign rd_state_req = addr_phase && !hwrite && (haddr == psru_pkg::OFS_STATE);
	assign rd_saved_req = addr_phase && !hwrite && (haddr == psru_pkg::OFS_SAVED);
	assign nmi_take = exc_in.take && exc_in.is_irq && irq_req.nmi;
	assign wr_ssie = hwdata[psru_pkg::POS_SSIE];
	assign wr_prs = hwdata[psru_pkg::POS_PRS +: psru_pkg::SET_W];

	// address phase capture; read data stands on hrdata through the data phase
	always_comb
	begin
		wr_pend_d = 1'b0;
		addr_d = addr_q;
		rd_d = rd_q;
		if (addr_phase)
		begin
			wr_pend_d = hwrite;
			addr_d = haddr;
			if (!hwrite)
				rd_d = (haddr == psru_pkg::OFS_STATE) ? st_word :
					(haddr == psru_pkg::OFS_SAVED) ? sav_q : 32'h00000000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wr_pend_q <= 1'b0;
			addr_q <= 32'h00000000;
			rd_q <= 32'h00000000;
		end
		else
		begin
			wr_pend_q <= wr_pend_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
		end
	end

	// state word and its saved copy
	always_comb
	begin
		st_d = st_q;
		sav_d = sav_q;
		if (sw_state_wr)
		begin
			// nmi and current set stay read-only
			st_d.ssie = (psru_pkg::HAS_EIC && psru_pkg::NUM_SETS > 1) ? wr_ssie : 1'b0;
			st_d.previous_reg_set = wr_prs;
			st_d.il = hwdata[psru_pkg::POS_IL +: 6];
			st_d.ih = hwdata[psru_pkg::POS_IH];
			st_d.eh = hwdata[psru_pkg::POS_EH];
			st_d.u = hwdata[psru_pkg::POS_U];
			st_d.pie = hwdata[psru_pkg::POS_PIE];
		end
		else if (sw_saved_wr)
			sav_d = hwdata;
		// hardware event wins over a software write in the same cycle
		if (exc_in.take)
		begin
			sav_d = st_word;
			if (take_copy)
				st_d.previous_reg_set = st_q.current_reg_set;
			st_d.eh = 1'b1;
			st_d.u = 1'b0;
			st_d.pie = 1'b0;
			if (exc_in.is_irq)
			begin
				st_d.ih = 1'b1;
				st_d.current_reg_set = irq_req.rset;
				st_d.il = irq_req.level;
				if (irq_req.nmi)
					st_d.nmi = 1'b1;
			end
			else
				st_d.current_reg_set = '0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_q <= '0;
			st_q.ssie <= (psru_pkg::HAS_EIC && psru_pkg::NUM_SETS > 1) ? psru_pkg::RST_SSIE : psru_pkg::RST_ZERO;
			sav_q <= 32'h00000000;
		end
		else
		begin
			st_q <= st_d;
			sav_q <= sav_d;
		end
	end

	assign hrdata = rd_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign state = st_q;
	assign saved_word = sav_q;

	property p_same_set_refuse;
		@(posedge clk) disable iff (reset)
		(irq_req.valid && !irq_req.nmi && !st_q.ssie && irq_req.rset == st_q.current_reg_set) |-> !irq_accept;
	endproperty
	a_same_set_refuse: assert property (p_same_set_refuse) else $error("same-set request accepted");
	property p_level;
		@(posedge clk) disable iff (reset)
		(irq_req.valid && !irq_req.nmi && irq_req.level <= st_q.il) |-> !irq_accept;
	endproperty
	a_level: assert property (p_level) else $error("low level accepted");
	property p_crs_clear;
		@(posedge clk) disable iff (reset)
		(exc_in.take && !exc_in.is_irq) |=> (st_q.current_reg_set == '0);
	endproperty
	a_crs_clear: assert property (p_crs_clear) else $error("current set not cleared");
	property p_copy;
		@(posedge clk) disable iff (reset)
		(exc_in.take && (exc_in.is_break || !st_q.eh)) |=> (st_q.previous_reg_set == $past(st_q.current_reg_set));
	endproperty
	a_copy: assert property (p_copy) else $error("set copy missing");
	property p_eh;
		@(posedge clk) disable iff (reset)
		exc_in.take |=> st_q.eh;
	endproperty
	a_eh: assert property (p_eh) else $error("exception mode not set");
	property p_ih;
		@(posedge clk) disable iff (reset)
		(exc_in.take && exc_in.is_irq) |=> st_q.ih;
	endproperty
	a_ih: assert property (p_ih) else $error("handler mode not set");
	property p_nmi;
		@(posedge clk) disable iff (reset)
		(exc_in.take && exc_in.is_irq && irq_req.nmi) |=> st_q.nmi ##1 st_q.nmi;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi bit not held");
	property p_saved;
		@(posedge clk) disable iff (reset)
		exc_in.take |=> (sav_q == $past(st_word));
	endproperty
	a_saved: assert property (p_saved) else $error("saved copy wrong");
	property p_range;
		@(posedge clk) disable iff (reset)
		(st_q.previous_reg_set < psru_pkg::NUM_SETS) && (st_q.current_reg_set < psru_pkg::NUM_SETS);
	endproperty
	a_range: assert property (p_range) else $error("set out of range");
	property p_ssie_rst;
		@(posedge clk) $fell(reset) |-> st_q.ssie;
	endproperty
	a_ssie_rst: assert property (p_ssie_rst) else $error("enable reset wrong");

	// enable set: a same-set request above the threshold must be taken
	property p_accept_same;
		@(posedge clk) disable iff (reset)
		(irq_req.valid && !irq_req.nmi && st_q.pie && irq_req.level > st_q.il && st_q.ssie) |-> irq_accept;
	endproperty
	a_accept_same: assert property (p_accept_same) else $error("same-set request refused");

	property p_accept_level;
		@(posedge clk) disable iff (reset)
		(irq_req.valid && !irq_req.nmi && st_q.pie && irq_req.level > st_q.il && irq_req.rset != st_q.current_reg_set) |-> irq_accept;
	endproperty
	a_accept_level: assert property (p_accept_level) else $error("high level refused");

	// enable bit is software writable in this configuration
	property p_ssie_write;
		@(posedge clk) disable iff (reset)
		sw_state_wr |=> (st_q.ssie == $past(wr_ssie));
	endproperty
	a_ssie_write: assert property (p_ssie_write) else $error("enable write lost");

	// only a nonmaskable take may raise the mode bit
	property p_nmi_source;
		@(posedge clk) disable iff (reset)
		$rose(st_q.nmi) |-> $past(nmi_take);
	endproperty
	a_nmi_source: assert property (p_nmi_source) else $error("nmi bit raised without nmi");

	property p_nmi_bus_ro;
		@(posedge clk) disable iff (reset)
		(sw_state_wr && !exc_in.take) |=> $stable(st_q.nmi);
	endproperty
	a_nmi_bus_ro: assert property (p_nmi_bus_ro) else $error("nmi bit written by bus");

	property p_nmi_reset;
		@(posedge clk) $fell(reset) |-> !st_q.nmi;
	endproperty
	a_nmi_reset: assert property (p_nmi_reset) else $error("nmi bit reset wrong");

	// nested non-break exception keeps the earlier previous set
	property p_no_copy;
		@(posedge clk) disable iff (reset)
		(exc_in.take && !exc_in.is_break && st_q.eh && !sw_state_wr) |=> $stable(st_q.previous_reg_set);
	endproperty
	a_no_copy: assert property (p_no_copy) else $error("set copied while nested");

	// saved copy must hold the set in use before the copy
	property p_copy_after_save;
		@(posedge clk) disable iff (reset)
		exc_in.take |=> (sav_q[psru_pkg::POS_CRS +: psru_pkg::SET_W] == $past(st_q.current_reg_set));
	endproperty
	a_copy_after_save: assert property (p_copy_after_save) else $error("saved set wrong");

	property p_crs_irq;
		@(posedge clk) disable iff (reset)
		(exc_in.take && exc_in.is_irq) |=> (st_q.current_reg_set == $past(irq_req.rset));
	endproperty
	a_crs_irq: assert property (p_crs_irq) else $error("requested set not loaded");

	// current set moves only with exceptions
	property p_crs_bus_ro;
		@(posedge clk) disable iff (reset)
		(sw_state_wr && !exc_in.take) |=> $stable(st_q.current_reg_set);
	endproperty
	a_crs_bus_ro: assert property (p_crs_bus_ro) else $error("current set written by bus");

	property p_prs_write;
		@(posedge clk) disable iff (reset)
		(sw_state_wr && !exc_in.take) |=> (st_q.previous_reg_set == $past(wr_prs));
	endproperty
	a_prs_write: assert property (p_prs_write) else $error("previous set write lost");

	property p_set_reset;
		@(posedge clk) $fell(reset) |-> (st_q.previous_reg_set == '0) && (st_q.current_reg_set == '0);
	endproperty
	a_set_reset: assert property (p_set_reset) else $error("set fields reset wrong");

	property p_il_load;
		@(posedge clk) disable iff (reset)
		(exc_in.take && exc_in.is_irq) |=> (st_q.il == $past(irq_req.level));
	endproperty
	a_il_load: assert property (p_il_load) else $error("threshold not loaded");

	// bus view of the word, unused set bits included
	property p_rd_state;
		@(posedge clk) disable iff (reset)
		rd_state_req |=> (hrdata == $past(st_word));
	endproperty
	a_rd_state: assert property (p_rd_state) else $error("state read wrong");

	property p_rd_saved;
		@(posedge clk) disable iff (reset)
		rd_saved_req |=> (hrdata == $past(sav_q));
	endproperty
	a_rd_saved: assert property (p_rd_saved) else $error("saved read wrong");

	property p_sav_write;
		@(posedge clk) disable iff (reset)
		(sw_saved_wr && !exc_in.take) |=> (sav_q == $past(hwdata));
	endproperty
	a_sav_write: assert property (p_sav_write) else $error("saved write lost");

	// handler entry masks further maskable requests
	property p_exc_mask;
		@(posedge clk) disable iff (reset)
		exc_in.take |=> (!st_q.u && !st_q.pie);
	endproperty
	a_exc_mask: assert property (p_exc_mask) else $error("entry did not mask");

	property p_accept_nmi;
		@(posedge clk) disable iff (reset)
		(irq_req.valid && irq_req.nmi) |-> irq_accept;
	endproperty
	a_accept_nmi: assert property (p_accept_nmi) else $error("nmi refused");

	property p_hold_ih;
		@(posedge clk) disable iff (reset)
		(exc_in.take && !exc_in.is_irq && !sw_state_wr) |=> $stable(st_q.ih);
	endproperty
	a_hold_ih: assert property (p_hold_ih) else $error("handler mode moved");

	c_irq: cover property (@(posedge clk) exc_in.take && exc_in.is_irq);
	c_break: cover property (@(posedge clk) exc_in.take && exc_in.is_break && st_q.eh);
	c_refuse: cover property (@(posedge clk) irq_req.valid && !irq_accept);
	c_write: cover property (@(posedge clk) wr_pend_q && addr_q == psru_pkg::OFS_STATE);
	c_nmi: cover property (@(posedge clk) nmi_take);
endmodule : psru_core

// ==== psru_pkg.sv ====
// psru_pkg: constants, types and register map of the processor state word update unit.
// assumes one core clock and an AHB-Lite master that issues single word transfers.
// Summary of operation
// - same-set irq enable one: accept interrupts asking for the set in use.
// - same-set irq enable zero: refuse maskable interrupts asking for the set in use.
// - same-set enable exists only with controller interface and shadow sets; resets to one.
// - nonmaskable interrupt sets the nonmaskable mode bit; read-only, resets zero.
// - without memory management unit, copy current set to previous on every exception.
// - with memory management unit, copy on break, else only while exception mode clear.
// - set copy happens together with saving the state word to its saved copy.
// - set fields hold 0 to n-1, minimal width for n-1.
// - unused high set-field bits read zero; software writes them zero.
// - any non-interrupt exception clears the current set field to zero.
// - set zero is the normal set; sets one and up are shadow sets.
// - maskable external interrupt serviced only when its level exceeds the threshold.
// - taking an external interrupt sets the interrupt handler mode bit.
// - any exception, breaks included, sets the exception handler mode bit.
package psru_pkg;
	localparam int NUM_SETS = 4;
	localparam int SET_W = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 1;
	localparam bit HAS_MMU = 1'b1;
	localparam bit HAS_EIC = 1'b1;
	localparam logic [31:0] OFS_STATE = 32'h00000000;
	localparam logic [31:0] OFS_SAVED = 32'h00000004;
	localparam int POS_SSIE = 23;
	localparam int POS_NMI = 22;
	localparam int POS_PRS = 16;
	localparam int POS_CRS = 10;
	localparam int POS_IL = 4;
	localparam int POS_IH = 3;
	localparam int POS_EH = 2;
	localparam int POS_U = 1;
	localparam int POS_PIE = 0;
	localparam logic RST_SSIE = 1'b1;
	localparam logic RST_ZERO = 1'b0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef struct packed {
		logic ssie;
		logic nmi;
		logic [SET_W-1:0] previous_reg_set;
		logic [SET_W-1:0] current_reg_set;
		logic [5:0] il;
		logic ih;
		logic eh;
		logic u;
		logic pie;
	} psru_state_s;
	typedef struct packed {
		logic valid;
		logic nmi;
		logic [5:0] level;
		logic [SET_W-1:0] rset;
	} psru_irq_s;
	typedef struct packed {
		logic take;
		logic is_irq;
		logic is_break;
	} psru_exc_s;
endpackage : psru_pkg

// ==== psru_src.sv ====
// psru_src: interrupt controller and exception source beside the state unit.
// assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/1ps
module psru_src (
	input wire logic clk, // core clock
	output psru_pkg::psru_irq_s irq_req, // controller request
	output psru_pkg::psru_exc_s exc_in // exception event
);
	initial
	begin
		irq_req = '0;
		exc_in = '0;
	end
	// request stays up as a level until replaced
	task automatic request(input logic nmi, input logic [5:0] lvl, input logic [psru_pkg::SET_W-1:0] rs);
		@(posedge clk);
		irq_req <= {1'b1, nmi, lvl, rs};
	endtask : request
	// one-cycle event pulse, as the unit expects
	task automatic fire(input logic irq, input logic brk);
		@(posedge clk);
		exc_in <= {1'b1, irq, brk};
		@(posedge clk);
		exc_in <= '0;
	endtask : fire
endmodule : psru_src

// ==== testbench.sv ====
// testbench: bus, interrupt and exception scenarios for the state unit.
// assumes zero-wait slave; state word at offset zero, saved copy at four.
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	psru_pkg::psru_irq_s irq_req;
	psru_pkg::psru_exc_s exc_in;
	logic irq_accept;
	psru_pkg::psru_state_s state;
	logic [31:0] saved_word;
	logic [31:0] rd;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	psru_core i_psru_core (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req), .exc_in(exc_in),
		.irq_accept(irq_accept), .state(state), .saved_word(saved_word));
	psru_src i_psru_src (.clk(clk), .irq_req(irq_req), .exc_in(exc_in));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= psru_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : xfer
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			final_report();
		end
	end
	task automatic t_reset_and_access;
		xfer(1'b0, psru_pkg::OFS_STATE, '0, rd);
		chk(rd, 32'h00800000);
		xfer(1'b1, psru_pkg::OFS_STATE, 32'hFFC303FF, rd);
		xfer(1'b0, psru_pkg::OFS_STATE, '0, rd);
		chk(rd, 32'h008303FF);
		xfer(1'b1, psru_pkg::OFS_SAVED, 32'hA5A55A5A, rd);
		xfer(1'b0, psru_pkg::OFS_SAVED, '0, rd);
		chk(rd, 32'hA5A55A5A);
		xfer(1'b0, 32'h00000040, '0, rd);
		chk(rd, 32'h0);
	endtask : t_reset_and_access
	task automatic t_accept;
		xfer(1'b1, psru_pkg::OFS_STATE, 32'h00000051, rd);
		i_psru_src.request(1'b0, 6'h05, 2'h1);
		#1 chk(irq_accept, 1'b0);
		i_psru_src.request(1'b0, 6'h06, 2'h1);
		#1 chk(irq_accept, 1'b1);
		i_psru_src.request(1'b0, 6'h06, 2'h0);
		#1 chk(irq_accept, 1'b0);
		xfer(1'b1, psru_pkg::OFS_STATE, 32'h00800051, rd);
		#1 chk(irq_accept, 1'b1);
	endtask : t_accept
	task automatic t_take;
		i_psru_src.request(1'b0, 6'h06, 2'h2);
		i_psru_src.fire(1'b1, 1'b0);
		#1 chk(saved_word, 32'h00800051);
		chk({state.current_reg_set, state.previous_reg_set, state.ih, state.eh, state.il}, {2'h2, 2'h0, 2'h3, 6'h06});
		xfer(1'b0, psru_pkg::OFS_SAVED, '0, rd);
		chk(rd, 32'h00800051);
		i_psru_src.fire(1'b0, 1'b1);
		#1 chk({state.current_reg_set, state.previous_reg_set}, {2'h0, 2'h2});
		xfer(1'b1, psru_pkg::OFS_STATE, 32'h00810000, rd);
		i_psru_src.fire(1'b0, 1'b0);
		#1 chk({state.previous_reg_set, state.eh}, {2'h0, 1'b1});
		xfer(1'b1, psru_pkg::OFS_STATE, 32'h00810004, rd);
		i_psru_src.fire(1'b0, 1'b0);
		#1 chk(state.previous_reg_set, 2'h1);
		i_psru_src.request(1'b1, 6'h01, 2'h1);
		i_psru_src.fire(1'b1, 1'b0);
		#1 chk(state.nmi, 1'b1);
	endtask : t_take
	// reset again after the nonmaskable take: all fields back to reset values
	task automatic t_mid_reset;
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		xfer(1'b0, psru_pkg::OFS_STATE, '0, rd);
		chk(rd, 32'h00800000);
		xfer(1'b0, psru_pkg::OFS_SAVED, '0, rd);
		chk(rd, 32'h0);
	endtask : t_mid_reset
	initial
	begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_reset_and_access();
		t_accept();
		t_take();
		t_mid_reset();
		final_report();
	end
endmodule : testbench
